// ### design/pomc_regs.vh
`ifndef POMC_REGS_VH
`define POMC_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define POMC_REG_CTRL      4'h0
`define POMC_REG_STATUS    4'h4
`define POMC_REG_BKPT_CTRL 4'h8
`define POMC_REG_BKPT_CMD  4'hc
// ----------------------------------------
// Control fields
// ----------------------------------------
`define POMC_CTRL_RUN_REQ  0
`define POMC_CTRL_COLD_OB  1
`define POMC_CTRL_RELOAD   2
`define POMC_CTRL_WDOG     3
// ----------------------------------------
// Command fields
// ----------------------------------------
`define POMC_CMD_STEP      0
`define POMC_CMD_RESUME    1
// ----------------------------------------
// Modes
// ----------------------------------------
`define POMC_MODE_STOP     2'h0
`define POMC_MODE_STARTUP  2'h1
`define POMC_MODE_RUN      2'h2
`define POMC_MODE_HOLD     2'h3
// ----------------------------------------
// Timing, breakpoint limits and bus responses
// ----------------------------------------
`define POMC_CLK_HZ        40000000
`define POMC_GREEN_MIN_S   3
`define POMC_PWRON_BLINK_S 1
`define POMC_HOLD_BLINK_HZ 1
`define POMC_MAX_BKPT      3
`define POMC_MAX_STEP_BKPT 2
`define POMC_RESP_OKAY     2'h0
`define POMC_RESP_SLVERR   2'h2
`endif

// ### design/pomc_top.v
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - STOP runs no program and asserts the output lock.
// RL2 - Yellow indicator lit steadily while in STOP.
// RL3 - After power-on yellow blinks in STOP, then turns steady shortly after.
// RL4 - Entering STOP keeps counters, timers, flags and process image.
// RL5 - STOP to RUN calls the startup block once, unsupervised.
// RL6 - Output lock held through START-UP.
// RL7 - Green blinks at least three seconds once startup begins.
// RL8 - After watchdog error stay STOP unless cold start block, reset or reload.
// RL9 - Green steady in RUN.
// RL10 - RUN runs main block cyclically, timers run, image refreshed each cycle.
// RL11 - RUN releases the output lock.
// RL12 - At most three breakpoints defined at once.
// RL13 - Reaching an active breakpoint in RUN enters HOLD, registers exposed.
// RL14 - HOLD: red steady, green blinks at one hertz.
// RL15 - HOLD halts all execution and freezes timers; clock keeps running.
// RL16 - Output lock held during HOLD.
// RL17 - From HOLD, step one statement or resume to next breakpoint.
// RL18 - Single step refused with more than two breakpoints defined.
// RL19 - Communication processor links stay up in HOLD.
// RL20 - Four exclusive modes, reset into STOP.
`include "pomc_regs.vh"
module pomc_top #(
    parameter GREEN_MIN_CYC = `POMC_GREEN_MIN_S * `POMC_CLK_HZ,
    parameter PWRON_CYC     = `POMC_PWRON_BLINK_S * `POMC_CLK_HZ,
    parameter HALF_HZ_CYC   = `POMC_CLK_HZ / (2 * `POMC_HOLD_BLINK_HZ)
)(
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Program engine
    input  wire        startup_done,
    input  wire        startup_error,
    input  wire        bkpt_hit,
    input  wire        step_done,
    input  wire [31:0] cpu_regs,
    output reg         startup_block_call,
    output reg         cold_start_block_call,
    output reg         cyclic_main_block_en,
    output reg         image_refresh,
    output reg         prog_timer_en,
    output reg         step_exec,
    output reg         supervise_en,
    output reg         comm_processor_keep,
    // Outputs and indicators
    output reg         output_lock,
    output reg         led_yellow,
    output reg         led_green,
    output reg         led_red,
    output reg  [1:0]  mode
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg        run_req_r;
    reg        cold_ob_r;
    reg        wdog_err_r;
    reg [1:0]  bkpt_cnt_r;
    reg        bkpt_en_r;
    reg        step_req_r;
    reg        resume_req_r;
    reg        step_rej_r;
    reg        stepping_r;
    reg [1:0]  mode_r;
    reg [31:0] green_cnt_r;
    reg        green_blink_r;
    reg [31:0] pwron_cnt_r;
    reg        pwron_blink_r;
    reg [31:0] half_cnt_r;
    reg        blink_ph_r;
    reg [31:0] held_regs_r;
    reg        aw_got_r;
    reg        w_got_r;
    reg [3:0]  aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_ctrl = wr_fire && aw_addr_r == `POMC_REG_CTRL && w_strb_r[0];
    wire wr_bkpt = wr_fire && aw_addr_r == `POMC_REG_BKPT_CTRL && w_strb_r[0];
    wire wr_cmd  = wr_fire && aw_addr_r == `POMC_REG_BKPT_CMD && w_strb_r[0];
    wire wr_map  = aw_addr_r == `POMC_REG_CTRL || aw_addr_r == `POMC_REG_BKPT_CTRL ||
                   aw_addr_r == `POMC_REG_BKPT_CMD;
    wire reload  = wr_ctrl && w_data_r[`POMC_CTRL_RELOAD];

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // ----------------------------------------
    // AXI write path
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            aw_addr_r    <= 4'h0;
            w_data_r     <= 32'h0;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `POMC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? `POMC_RESP_OKAY : `POMC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // AXI read path
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `POMC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `POMC_RESP_OKAY;
            case (s_axi_araddr)
                `POMC_REG_CTRL:
                    s_axi_rdata <= {28'h0, wdog_err_r, 1'b0, cold_ob_r, run_req_r};
                `POMC_REG_STATUS:
                    s_axi_rdata <= {24'h0, step_rej_r, bkpt_en_r, bkpt_cnt_r,
                                    output_lock, 1'b0, mode_r};
                `POMC_REG_BKPT_CTRL:
                    s_axi_rdata <= {29'h0, bkpt_en_r, bkpt_cnt_r};
                `POMC_REG_BKPT_CMD:
                    s_axi_rdata <= held_regs_r; // RL13
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `POMC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_req_r    <= 1'b0;
            cold_ob_r    <= 1'b0;
            wdog_err_r   <= 1'b0;
            bkpt_cnt_r   <= 2'h0;
            bkpt_en_r    <= 1'b0;
            step_req_r   <= 1'b0;
            resume_req_r <= 1'b0;
            step_rej_r   <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                run_req_r <= w_data_r[`POMC_CTRL_RUN_REQ];
                cold_ob_r <= w_data_r[`POMC_CTRL_COLD_OB];
            end
            // Watchdog error sticky; set wins over reload clear
            if (wr_ctrl && w_data_r[`POMC_CTRL_WDOG])
                wdog_err_r <= 1'b1;
            else if (reload)
                wdog_err_r <= 1'b0; // RL8
            if (wr_bkpt)
            begin
                bkpt_en_r <= w_data_r[2];
                if (w_data_r[1:0] <= `POMC_MAX_BKPT) // RL12
                    bkpt_cnt_r <= w_data_r[1:0];
            end
            step_req_r   <= 1'b0;
            resume_req_r <= 1'b0;
            if (wr_cmd && mode_r == `POMC_MODE_HOLD)
            begin
                if (w_data_r[`POMC_CMD_STEP])
                begin
                    if (bkpt_cnt_r > `POMC_MAX_STEP_BKPT)
                        step_rej_r <= 1'b1; // RL18
                    else
                    begin
                        step_req_r <= 1'b1; // RL17
                        step_rej_r <= 1'b0;
                    end
                end
                if (w_data_r[`POMC_CMD_RESUME])
                    resume_req_r <= 1'b1; // RL17
            end
        end
    end

    // ----------------------------------------
    // Mode sequencer
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r      <= `POMC_MODE_STOP; // RL20
            stepping_r  <= 1'b0;
            held_regs_r <= 32'h0;
        end
        else
        begin
            case (mode_r)
                `POMC_MODE_STOP:
                    if (run_req_r && (!wdog_err_r || cold_ob_r)) // RL8
                        mode_r <= `POMC_MODE_STARTUP; // RL5
                `POMC_MODE_STARTUP:
                    if (startup_error || !run_req_r)
                        mode_r <= `POMC_MODE_STOP;
                    else if (startup_done)
                        mode_r <= `POMC_MODE_RUN;
                `POMC_MODE_RUN:
                    if (!run_req_r)
                        mode_r <= `POMC_MODE_STOP; // RL4
                    else if (bkpt_hit && bkpt_en_r && bkpt_cnt_r != 2'h0)
                    begin
                        mode_r      <= `POMC_MODE_HOLD; // RL13
                        held_regs_r <= cpu_regs;
                    end
                `POMC_MODE_HOLD:
                    if (!run_req_r)
                    begin
                        mode_r     <= `POMC_MODE_STOP;
                        stepping_r <= 1'b0;
                    end
                    else if (resume_req_r)
                        mode_r <= `POMC_MODE_RUN; // RL17
                    else if (step_req_r)
                        stepping_r <= 1'b1;
                    else if (stepping_r && step_done)
                    begin
                        stepping_r  <= 1'b0;
                        held_regs_r <= cpu_regs;
                    end
                default:
                    mode_r <= `POMC_MODE_STOP;
            endcase
        end
    end

    // ----------------------------------------
    // Indicator timers
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            green_cnt_r   <= 32'h0;
            green_blink_r <= 1'b0;
            pwron_cnt_r   <= 32'h0;
            pwron_blink_r <= 1'b1;
            half_cnt_r    <= 32'h0;
            blink_ph_r    <= 1'b0;
        end
        else
        begin
            if (half_cnt_r >= HALF_HZ_CYC - 1)
            begin
                half_cnt_r <= 32'h0;
                blink_ph_r <= ~blink_ph_r;
            end
            else
                half_cnt_r <= half_cnt_r + 32'h1;
            if (mode_r == `POMC_MODE_STOP && run_req_r && (!wdog_err_r || cold_ob_r))
            begin
                green_blink_r <= 1'b1; // RL7
                green_cnt_r   <= 32'h0;
            end
            else if (green_blink_r)
            begin
                if (green_cnt_r >= GREEN_MIN_CYC - 1)
                    green_blink_r <= 1'b0;
                else
                    green_cnt_r <= green_cnt_r + 32'h1;
            end
            if (pwron_blink_r)
            begin
                if (pwron_cnt_r >= PWRON_CYC - 1)
                    pwron_blink_r <= 1'b0; // RL3
                else
                    pwron_cnt_r <= pwron_cnt_r + 32'h1;
            end
        end
    end

    // ----------------------------------------
    // Mode outputs
    // ----------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            output_lock           <= 1'b1;
            led_yellow            <= 1'b0;
            led_green             <= 1'b0;
            led_red               <= 1'b0;
            mode                  <= `POMC_MODE_STOP;
            startup_block_call    <= 1'b0;
            cold_start_block_call <= 1'b0;
            cyclic_main_block_en  <= 1'b0;
            image_refresh         <= 1'b0;
            prog_timer_en         <= 1'b0;
            step_exec             <= 1'b0;
            supervise_en          <= 1'b0;
            comm_processor_keep   <= 1'b0;
        end
        else
        begin
            mode                  <= mode_r;
            output_lock           <= mode_r != `POMC_MODE_RUN; // RL1 RL6 RL11 RL16
            led_yellow            <= mode_r == `POMC_MODE_STOP &&
                                     (!pwron_blink_r || blink_ph_r); // RL2 RL3
            led_red               <= mode_r == `POMC_MODE_HOLD; // RL14
            if (green_blink_r)
                led_green <= blink_ph_r; // RL7
            else if (mode_r == `POMC_MODE_HOLD)
                led_green <= blink_ph_r; // RL14
            else
                led_green <= mode_r == `POMC_MODE_RUN; // RL9
            startup_block_call    <= mode_r == `POMC_MODE_STOP && run_req_r &&
                                     !wdog_err_r; // RL5
            cold_start_block_call <= mode_r == `POMC_MODE_STOP && run_req_r &&
                                     wdog_err_r && cold_ob_r; // RL8
            supervise_en          <= mode_r == `POMC_MODE_RUN; // RL5
            cyclic_main_block_en  <= mode_r == `POMC_MODE_RUN; // RL1 RL10 RL15
            image_refresh         <= mode_r == `POMC_MODE_RUN && step_done; // RL10
            prog_timer_en         <= mode_r == `POMC_MODE_RUN; // RL4 RL15
            step_exec             <= mode_r == `POMC_MODE_HOLD && step_req_r; // RL17
            comm_processor_keep   <= 1'b1; // RL19
        end
    end
endmodule // pomc_top

// ### bench/pomc_monitor.sv
`timescale 1ns/1ps
`include "pomc_regs.vh"
module pomc_monitor #(
    parameter PWRON_CYC = 20
)(
    // Clock and reset
    input wire       aclk,
    input wire       aresetn,
    // Mode and indicators
    input wire [1:0] mode,
    input wire       output_lock,
    input wire       led_yellow,
    input wire       led_red,
    // Engine controls
    input wire       startup_block_call,
    input wire       cold_start_block_call,
    input wire       cyclic_main_block_en,
    input wire       prog_timer_en,
    input wire       supervise_en,
    input wire       image_refresh,
    input wire       step_exec,
    input wire       comm_processor_keep
);
    // ----------------------------------------
    // Time since reset
    // ----------------------------------------
    integer up_r;
    always @(posedge aclk)
    begin
        if (!aresetn)
            up_r <= 0;
        else if (up_r < PWRON_CYC + 4)
            up_r <= up_r + 1;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence call_s;
        startup_block_call || cold_start_block_call;
    endsequence
    sequence enter_su_s;
        ##[0:2] (mode == `POMC_MODE_STARTUP);
    endsequence
    lock_not_run_a: assert property (mode != `POMC_MODE_RUN |-> output_lock)
        else $error("output lock low outside run");
    lock_run_a: assert property (mode == `POMC_MODE_RUN |-> !output_lock)
        else $error("output lock high in run");
    yellow_steady_a: assert property ((up_r == PWRON_CYC + 4) && (mode == `POMC_MODE_STOP)
        |-> led_yellow)
        else $error("yellow not steady in stop");
    call_startup_a: assert property (call_s |-> enter_su_s)
        else $error("startup call without startup mode");
    no_supervise_a: assert property (mode == `POMC_MODE_STARTUP |-> !supervise_en)
        else $error("startup supervised");
    run_exec_a: assert property (mode == `POMC_MODE_RUN |-> cyclic_main_block_en && prog_timer_en)
        else $error("run without cyclic execution");
    hold_frozen_a: assert property (mode == `POMC_MODE_HOLD
        |-> !cyclic_main_block_en && !prog_timer_en)
        else $error("execution in hold");
    refresh_run_a: assert property (image_refresh
        |-> (mode == `POMC_MODE_RUN) || ($past(mode) == `POMC_MODE_RUN))
        else $error("image refresh outside run");
    hold_entry_a: assert property ($rose(mode == `POMC_MODE_HOLD)
        |-> $past(mode) == `POMC_MODE_RUN)
        else $error("hold entered not from run");
    red_hold_a: assert property (led_red == (mode == `POMC_MODE_HOLD))
        else $error("red indicator wrong");
    step_pulse_a: assert property (step_exec
        |-> ($past(mode) == `POMC_MODE_HOLD) ##1 !step_exec)
        else $error("step outside hold");
    comm_keep_a: assert property (mode == `POMC_MODE_HOLD |-> comm_processor_keep)
        else $error("links dropped in hold");
endmodule // pomc_monitor

bind pomc_top pomc_monitor #(.PWRON_CYC(PWRON_CYC)) i_mon (
    .aclk                  (aclk),
    .aresetn               (aresetn),
    .mode                  (mode),
    .output_lock           (output_lock),
    .led_yellow            (led_yellow),
    .led_red               (led_red),
    .startup_block_call    (startup_block_call),
    .cold_start_block_call (cold_start_block_call),
    .cyclic_main_block_en  (cyclic_main_block_en),
    .prog_timer_en         (prog_timer_en),
    .supervise_en          (supervise_en),
    .image_refresh         (image_refresh),
    .step_exec             (step_exec),
    .comm_processor_keep   (comm_processor_keep)
);

// ### bench/pomc_engine_model.sv
`timescale 1ns/1ps
`include "pomc_regs.vh"
module pomc_engine_model (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Bench controls
    input wire        fail_req,
    input wire        hit_req,
    // Device side
    input wire [1:0]  mode,
    input wire        step_exec,
    output reg        startup_done,
    output reg        startup_error,
    output reg        bkpt_hit,
    output reg        step_done,
    output reg [31:0] cpu_regs
);
    reg [2:0] su_cnt_r;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            su_cnt_r <= 3'h0;
            startup_done <= 1'b0;
            startup_error <= 1'b0;
            bkpt_hit <= 1'b0;
            step_done <= 1'b0;
            cpu_regs <= 32'h0;
        end
        else
        begin
            su_cnt_r <= (mode == `POMC_MODE_STARTUP) ? su_cnt_r + {2'h0, su_cnt_r != 3'h7} : 3'h0;
            startup_done <= (mode == `POMC_MODE_STARTUP) && (su_cnt_r == 3'h3) && !fail_req;
            startup_error <= (mode == `POMC_MODE_STARTUP) && (su_cnt_r == 3'h3) && fail_req;
            bkpt_hit <= hit_req;
            step_done <= step_exec || ((mode == `POMC_MODE_RUN) && (cpu_regs[1:0] == 2'h3));
            if (mode == `POMC_MODE_RUN)
                cpu_regs <= cpu_regs + 32'h1;
        end
    end
endmodule // pomc_engine_model

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "pomc_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fail_req, hit_req;
    reg  [3:0]  awaddr, araddr, wstrb;
    reg  [31:0] wdata, rd, rd2;
    reg  [1:0]  rs;
    wire        awready, wready, bvalid, arready, rvalid, s_done, s_err, b_hit, st_done;
    wire [1:0]  bresp, rresp, mode;
    wire [31:0] rdata, cpu_regs;
    wire        sbc, cbc, cyc_en, img_r, tmr_en, step_exec, sup_en, ln_keep;
    wire        output_lock, led_yellow, led_green, led_red;
    integer     fails = 0, n_compared = 0, g_tog = 0, y_tog = 0, step_n = 0, refr_n = 0;
    integer     i, g0, s0;
    reg         g_q, y_q;
    localparam logic [69:0] ROWS [4] = '{{4'h8, 32'h5, 32'h5, 2'h0},
        {4'h8, 32'hfffffff3, 32'h3, 2'h0}, {4'h0, 32'h0, 32'h0, 2'h0},
        {4'h2, 32'h1, 32'h0, `POMC_RESP_SLVERR}};
    reg  [69:0] row;
    pomc_top #(.GREEN_MIN_CYC(40), .PWRON_CYC(20), .HALF_HZ_CYC(5)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .startup_done(s_done), .startup_error(s_err), .bkpt_hit(b_hit), .step_done(st_done),
        .cpu_regs(cpu_regs), .startup_block_call(sbc), .cold_start_block_call(cbc),
        .cyclic_main_block_en(cyc_en), .image_refresh(img_r), .prog_timer_en(tmr_en),
        .step_exec(step_exec), .supervise_en(sup_en), .comm_processor_keep(ln_keep),
        .output_lock(output_lock), .led_yellow(led_yellow), .led_green(led_green),
        .led_red(led_red), .mode(mode));
    pomc_engine_model i_eng (.aclk(aclk), .aresetn(aresetn), .fail_req(fail_req),
        .hit_req(hit_req), .mode(mode), .step_exec(step_exec), .startup_done(s_done),
        .startup_error(s_err), .bkpt_hit(b_hit), .step_done(st_done), .cpu_regs(cpu_regs));
    // ----------------------------------------
    // Clock and event counts
    // ----------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        g_q <= led_green;
        y_q <= led_yellow;
        g_tog <= g_tog + (g_q !== led_green);
        y_tog <= y_tog + (aresetn && y_q !== led_yellow);
        step_n <= step_n + (step_exec === 1'b1);
        refr_n <= refr_n + (img_r === 1'b1);
    end
    // ----------------------------------------
    // Bus tasks, mode wait, end of test and timeout
    // ----------------------------------------
    task axw(input [3:0] a, input [31:0] d, input [1:0] er);
        reg ad, wd;
        begin
            ad = 1'b0;
            wd = 1'b0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(ad && wd))
            begin
                @(posedge aclk);
                ad = ad | awready;
                wd = wd | wready;
                if (ad) awvalid <= 1'b0;
                if (wd) wvalid <= 1'b0;
            end
            while (bvalid !== 1'b1) @(posedge aclk);
            `CHK("bresp", er, bresp)
            bready <= 1'b0;
        end
    endtask
    task axr(input [3:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(posedge aclk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            do @(posedge aclk); while (rvalid !== 1'b1);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
    task wait_mode(input [1:0] m);
        for (i = 0; i < 200 && mode !== m; i++) @(posedge aclk);
        `CHK("mode", m, mode)
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_of_test;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fail_req, hit_req} = 8'h0;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hf;
        repeat (16) @(posedge aclk);
        `CHK("lock_rst", 1'b1, output_lock)
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("mode_rst", `POMC_MODE_STOP, mode)
        repeat (18) @(posedge aclk);
        `CHK("yel_blink", 1'b1, y_tog > 1)
        repeat (10) @(posedge aclk);
        g0 = y_tog;
        repeat (12) @(posedge aclk);
        `CHK("yel_steady", g0, y_tog)
        for (s0 = 0; s0 < 4; s0++)
        begin
            row = ROWS[s0];
            axw(row[69:66], row[65:34], row[1:0]);
            axr(row[69:66], rd, rs);
            `CHK("rd_data", row[33:2], rd)
            `CHK("rd_resp", row[1:0], rs)
        end
        axr(`POMC_REG_STATUS, rd, rs);
        `CHK("status", 8'h38, rd[7:0])
        fail_req <= 1'b1;
        axw(`POMC_REG_CTRL, 32'h9, `POMC_RESP_OKAY);
        repeat (20) @(posedge aclk);
        `CHK("wdog_stop", `POMC_MODE_STOP, mode)
        axw(`POMC_REG_CTRL, 32'hb, `POMC_RESP_OKAY);
        wait_mode(`POMC_MODE_STARTUP);
        `CHK("lock_su", 1'b1, output_lock)
        axw(`POMC_REG_CTRL, 32'h8, `POMC_RESP_OKAY);
        wait_mode(`POMC_MODE_STOP);
        repeat (15) @(posedge aclk);
        g0 = g_tog;
        repeat (12) @(posedge aclk);
        `CHK("green_err", 1'b1, g_tog != g0)
        fail_req <= 1'b0;
        axw(`POMC_REG_CTRL, 32'h5, `POMC_RESP_OKAY);
        wait_mode(`POMC_MODE_RUN);
        repeat (45) @(posedge aclk);
        `CHK("green_run", 1'b1, led_green)
        `CHK("lock_run", 1'b0, output_lock)
        g0 = refr_n;
        repeat (10) @(posedge aclk);
        `CHK("refresh", 1'b1, refr_n != g0)
        axr(`POMC_REG_STATUS, rd, rs);
        `CHK("st_run", 4'h2, rd[3:0])
        axw(`POMC_REG_BKPT_CTRL, 32'h6, `POMC_RESP_OKAY);
        @(posedge aclk);
        hit_req <= 1'b1;
        @(posedge aclk);
        hit_req <= 1'b0;
        wait_mode(`POMC_MODE_HOLD);
        `CHK("red", 1'b1, led_red)
        `CHK("lock_hold", 1'b1, output_lock)
        `CHK("ln_keep", 1'b1, ln_keep)
        g0 = g_tog;
        axr(`POMC_REG_BKPT_CMD, rd, rs);
        repeat (8) @(posedge aclk);
        axr(`POMC_REG_BKPT_CMD, rd2, rs);
        `CHK("regs_held", rd, rd2)
        `CHK("green_hold", 1'b1, g_tog != g0)
        s0 = step_n;
        axw(`POMC_REG_BKPT_CMD, 32'h1, `POMC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK("step", s0 + 1, step_n)
        wait_mode(`POMC_MODE_HOLD);
        axw(`POMC_REG_BKPT_CTRL, 32'h7, `POMC_RESP_OKAY);
        s0 = step_n;
        axw(`POMC_REG_BKPT_CMD, 32'h1, `POMC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK("step_rej", s0, step_n)
        axr(`POMC_REG_STATUS, rd, rs);
        `CHK("st_rej", 3'h7, rd[7:5])
        axr(`POMC_REG_BKPT_CMD, rd2, rs);
        axw(`POMC_REG_BKPT_CMD, 32'h2, `POMC_RESP_OKAY);
        wait_mode(`POMC_MODE_RUN);
        axw(`POMC_REG_CTRL, 32'h0, `POMC_RESP_OKAY);
        wait_mode(`POMC_MODE_STOP);
        axr(`POMC_REG_BKPT_CMD, rd, rs);
        `CHK("kept", rd2, rd)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHK("mode_rst2", `POMC_MODE_STOP, mode)
        `CHK("lock_rst2", 1'b1, output_lock)
        end_of_test;
    end
endmodule // testbench
